// file: common/trace_port_pkg.sv
// trace_port_pkg: constants, types and register map of the companion debug port
// Notes on behaviour
// RULE_01: trace leaves on up to six serial lanes, striped across every active lane; the code puts data on lanes 0 to 3 only, lanes 4 and 5 send commas.
// RULE_02: the tool supplies the link clock at the bit rate and the lanes shift on it.
// RULE_03: after reset an asserted event input asks for sync messages or a breakpoint.
// RULE_04: an event input held through reset leaves the device halted in debug mode; the code looks at event pin 0 only.
// RULE_05: a watchpoint or semaphore trigger drives the event output pin at once.
// RULE_06: each event pin is set as input or output, and an unnumbered pin is pin 0.
// RULE_07: the lane link takes 30 data and 2 start/end bits and 8b10b encodes each lane.
// RULE_08: the encoded lane symbols are serialised onto the differential lane pins.
// RULE_09: the router filters trace and steers each message to memory or to the link.
// RULE_10: switch code 0x3E on the scan controller hands scan control to the main die.
// RULE_11: once the main die holds scan control the switch code is ignored.
// RULE_12: the memory has four partitions, one to four of them given to overlay use.
// RULE_13: the trace buffer is one contiguous base and size region inside trace space.
// RULE_14: one-shot capture stops when full, circular capture wraps until stopped.
// RULE_15: the access client reaches the memory from the scan side without the main die.
// RULE_16: the block runs on its own local clock whether or not the main die is powered.
// RULE_17: encoded bytes go to the active lanes round-robin starting at lane zero.
package trace_port_pkg;
	localparam int LANES = 6;
	localparam int PARTS = 4;
	localparam int PART_WORDS = 64;
	localparam int MEM_WORDS = PARTS * PART_WORDS;
	localparam int CLOCK_KHZ = 50000;
	localparam int EVT_OUT_NS = 80;
	localparam int EVT_OUT_CYCLES = (EVT_OUT_NS * CLOCK_KHZ + 999999) / 1000000;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_PART = 8'h04;
	localparam logic [7:0] REG_BASE = 8'h08;
	localparam logic [7:0] REG_SIZE = 8'h0C;
	localparam logic [7:0] REG_WPTR = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [7:0] REG_MASK = 8'h18;
	localparam logic [7:0] REG_STATE = 8'h1C;
	localparam logic [7:0] REG_TICK = 8'h20;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [7:0] SWITCH_IR = 8'h3E;
	localparam int CTRL_RELEASE_BIT = 10;
	localparam logic [9:0] CTRL_RST = 10'h008;
	localparam logic [2:0] PART_RST = 3'h1;
	localparam logic [7:0] BASE_RST = 8'h40;
	localparam logic [8:0] SIZE_RST = 9'h0C0;
	localparam int ST_FULL = 0;
	localparam int ST_WRAP = 1;
	localparam int ST_EVENT = 2;
	localparam int ST_REGION = 3;
	localparam int ST_SWITCH = 4;
	localparam int ST_W = 5;
	localparam logic [9:0] K285_NEG = 10'h0FA;
	localparam logic [9:0] K285_POS = 10'h305;
	localparam logic [5:0] ENC6 [32] = '{6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
		6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17, 6'h1B, 6'h23, 6'h13, 6'h32,
		6'h0B, 6'h2A, 6'h1A, 6'h3A, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
	localparam logic [3:0] ENC4 [8] = '{4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

	typedef struct packed {
		logic [1:0] evAction; // 1 = breakpoint, 0 = sync messages
		logic [1:0] evDir; // 1 = pin is an event output
		logic [2:0] laneCount;
		logic circular;
		logic routeToMem;
		logic captureEn;
	} ctrl_type;

	typedef struct packed {
		logic [1:0] startEnd;
		logic [29:0] data;
	} msg_type;
endpackage

// file: core/trace_debug_companion_port.sv
// trace_debug_companion_port: router, lane link, event pins, scan switch and trace memory
`timescale 1ns/10ps
module trace_debug_companion_port (
	input wire logic clock, // local clock
	input wire logic sys_rst, // synchronous reset, high
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire trace_port_pkg::msg_type msgIn, // trace message from main die
	input wire logic msgValid, // message valid
	output logic msgReady, // message ready
	input wire logic linkClkIn, // tool link clock, bit rate
	output logic [5:0] laneTxP, // lane positive
	output logic [5:0] laneTxN, // lane negative
	input wire logic [1:0] eventInN, // event pin level, low active
	output logic [1:0] eventOutN, // event pin drive, low active
	output logic [1:0] eventOeN, // event pin enable, low drives
	input wire logic watchHit, // watchpoint or breakpoint pulse
	input wire logic semaphoreHit, // semaphore trigger pulse
	output logic syncReq, // sync message request pulse
	output logic breakReq, // breakpoint request pulse
	output logic debugHalt, // hold core in debug mode
	input wire logic tapIrUpdate, // scan instruction update pulse
	input wire logic [7:0] tapIr, // scan instruction
	input wire logic tapReset, // scan logic reset
	output logic mainDieScanSel, // scan path handed to main die
	input wire logic rwReq, // access request pulse
	input wire logic rwWrite, // access is a write
	input wire logic [7:0] rwAddr, // access word address
	input wire logic [31:0] rwWdata, // access write data
	output logic rwAck, // access done pulse
	output logic [31:0] rwRdata, // access read data
	output logic irq // interrupt level
);
	import trace_port_pkg::*;

	ctrl_type ctrl;
	logic [2:0] ovlParts;
	logic [7:0] trBase;
	logic [8:0] trSize;
	logic [7:0] wptr;
	logic stopped;
	logic [ST_W-1:0] status;
	logic [ST_W-1:0] mask;
	logic [ST_W-1:0] stSet;
	logic [ST_W-1:0] next_status;
	logic [31:0] tick;
	logic [7:0] awAddr;
	logic [31:0] wData;
	logic [3:0] wStrb;
	logic doWrite;
	logic [31:0] rdMux;
	logic rdHit;
	logic [31:0] mem [MEM_WORDS];
	logic linkFull;
	logic next_linkFull;
	logic [31:0] linkWord;
	logic [2:0] cursor;
	logic lkS1, lkS2, lkS3;
	logic linkRise;
	logic [3:0] bitCnt;
	logic slotEdge;
	logic [1:0] evS1, evS2, evDly;
	logic [1:0] evRise;
	logic started;
	logic [2:0] evCnt;
	logic [2:0] next_evCnt;
	logic rwPend;
	logic rwPendWr;
	logic [7:0] rwA;
	logic [31:0] rwD;
	logic next_rwPend;
	logic take;
	logic memTake;
	logic linkTake;
	logic regionOk;
	logic [9:0] trEnd;
	logic atEnd;

	// byte-masked merge of a write into a register value
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[8*b +: 8] = d[8*b +: 8];
			end
		end
		return r;
	endfunction

	// 8b10b encode with running disparity; returns {new rd, abcdei fghj}
	function automatic logic [10:0] enc8b10b(input logic [7:0] d, input logic k,
		input logic rd);
		logic [5:0] s6;
		logic [3:0] s4;
		logic r;
		logic un6;
		logic un4;
		s6 = ENC6[d[4:0]];
		un6 = ($countones(s6) != 3);
		r = rd;
		if ((un6 || d[4:0] == 5'h07) && rd) begin
			s6 = ~s6;
		end
		if (un6) begin
			r = ~rd;
		end
		s4 = ENC4[d[7:5]];
		if (d[7:5] == 3'h7 && ((!r && (d[4:0] == 5'h11 || d[4:0] == 5'h12 ||
			d[4:0] == 5'h14)) || (r && (d[4:0] == 5'h0B || d[4:0] == 5'h0D ||
			d[4:0] == 5'h0E)))) begin
			s4 = 4'h7;
		end
		un4 = ($countones(s4) != 2);
		if ((un4 || d[7:5] == 3'h3) && r) begin
			s4 = ~s4;
		end
		if (un4) begin
			r = ~r;
		end
		if (k) begin
			return rd ? {1'b0, K285_POS} : {1'b1, K285_NEG};
		end
		return {r, s6, s4};
	endfunction

	// ----------------------------------------------------------------
	// register bus slave
	// ----------------------------------------------------------------
	assign doWrite = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

	// address and data are taken in either order, answered once both are held
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			awAddr <= 8'h00;
			wData <= 32'h0000_0000;
			wStrb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awAddr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wData <= s_axi_wdata;
				wStrb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (doWrite) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awAddr > REG_MASK || awAddr[1:0] != 2'h0) ? RESP_SLVERR
					: RESP_OKAY;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// read decode
	always_comb begin
		rdMux = 32'h0000_0000;
		rdHit = 1'b1;
		unique case (s_axi_araddr)
			REG_CTRL: rdMux = {22'h0, ctrl};
			REG_PART: rdMux = {29'h0, ovlParts};
			REG_BASE: rdMux = {24'h0, trBase};
			REG_SIZE: rdMux = {23'h0, trSize};
			REG_WPTR: rdMux = {24'h0, wptr};
			REG_STATUS: rdMux = {27'h0, status};
			REG_MASK: rdMux = {27'h0, mask};
			REG_STATE: rdMux = {27'h0, mainDieScanSel, debugHalt, linkFull, stopped, started};
			REG_TICK: rdMux = tick;
			default: rdHit = 1'b0;
		endcase
	end

	// read channel, one outstanding read
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rdMux;
			s_axi_rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// configuration registers
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ctrl <= ctrl_type'(CTRL_RST);
			ovlParts <= PART_RST;
			trBase <= BASE_RST;
			trSize <= SIZE_RST;
			mask <= '0;
		end else if (doWrite) begin
			unique case (awAddr)
				REG_CTRL: ctrl <= ctrl_type'(merge({22'h0, ctrl}, wData, wStrb) & 32'h3FF);
				// RULE_12 overlay share
				REG_PART: begin
					if (wStrb[0] && wData[2:0] != 3'h0 && wData[2:0] <= 3'(PARTS)) begin
						ovlParts <= wData[2:0];
					end
				end
				REG_BASE: trBase <= 8'(merge({24'h0, trBase}, wData, wStrb));
				REG_SIZE: trSize <= 9'(merge({23'h0, trSize}, wData, wStrb));
				REG_MASK: mask <= ST_W'(merge({27'h0, mask}, wData, wStrb));
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// interrupt status
	// ----------------------------------------------------------------
	// set wins over a write-one clear in the same cycle
	always_comb begin
		next_status = status | stSet;
		if (doWrite && awAddr == REG_STATUS && wStrb[0]) begin
			next_status = (status & ~wData[ST_W-1:0]) | stSet;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			status <= '0;
			irq <= 1'b0;
		end else begin
			status <= next_status;
			irq <= |(next_status & mask);
		end
	end

	// RULE_16 free-running count on the local clock
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			tick <= 32'h0000_0000;
		end else begin
			tick <= tick + 32'h0000_0001;
		end
	end

	// ----------------------------------------------------------------
	// trace router and trace memory
	// ----------------------------------------------------------------
	assign take = msgValid && msgReady;
	// RULE_09 filter and steer
	assign memTake = take && ctrl.captureEn && ctrl.routeToMem && !stopped && regionOk;
	assign linkTake = take && ctrl.captureEn && !ctrl.routeToMem;
	assign trEnd = {2'b00, trBase} + {1'b0, trSize};
	// RULE_13 region must be contiguous and lie in trace partitions
	assign regionOk = trSize != 9'h000 && trEnd <= 10'(MEM_WORDS)
		&& {2'b00, trBase} >= 10'(ovlParts * PART_WORDS);
	assign atEnd = {2'b00, wptr} + 10'h001 >= trEnd;
	assign next_rwPend = rwReq || (rwPend && take);
	assign next_linkFull = linkTake ? 1'b1
		: (slotEdge && linkFull && ({1'b0, cursor} + {1'b0, ctrl.laneCount} >= 4'h4)) ? 1'b0
		: linkFull;

	// back-pressure: link holds one word, memory yields to a pending access
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			msgReady <= 1'b0;
		end else begin
			msgReady <= ctrl.routeToMem ? !next_rwPend : !next_linkFull;
		end
	end

	// RULE_14 one-shot stop, circular wrap
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			wptr <= BASE_RST;
			stopped <= 1'b0;
		end else if (doWrite && (awAddr == REG_BASE || awAddr == REG_SIZE)) begin
			wptr <= (awAddr == REG_BASE) ? 8'(merge({24'h0, trBase}, wData, wStrb)) : trBase;
			stopped <= 1'b0;
		end else if (memTake) begin
			if (!atEnd) begin
				wptr <= wptr + 8'h01;
			end else if (ctrl.circular) begin
				wptr <= trBase;
			end else begin
				stopped <= 1'b1;
			end
		end
	end

	// RULE_15 scan-side access shares the memory with capture
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rwPend <= 1'b0;
			rwPendWr <= 1'b0;
			rwA <= 8'h00;
			rwD <= 32'h0000_0000;
			rwAck <= 1'b0;
			rwRdata <= 32'h0000_0000;
		end else begin
			rwAck <= 1'b0;
			if (rwReq) begin
				rwPendWr <= rwWrite;
				rwA <= rwAddr;
				rwD <= rwWdata;
			end
			rwPend <= next_rwPend;
			if (rwPend && !take) begin
				rwPend <= rwReq;
				rwAck <= 1'b1;
				rwRdata <= mem[rwA];
			end
		end
	end

	// single write port for capture and access
	always_ff @(posedge clock) begin
		if (memTake) begin
			mem[wptr] <= msgIn;
		end else if (rwPend && !take && rwPendWr) begin
			mem[rwA] <= rwD;
		end
	end

	// ----------------------------------------------------------------
	// lane link and serial stage
	// ----------------------------------------------------------------
	// RULE_02 tool clock sampled and its rising edges found
	always_ff @(posedge clock) begin
		lkS1 <= linkClkIn;
		lkS2 <= lkS1;
		lkS3 <= lkS2;
	end
	assign linkRise = lkS2 && !lkS3;
	assign slotEdge = linkRise && bitCnt == 4'h9;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			bitCnt <= 4'h0;
		end else if (linkRise) begin
			bitCnt <= (bitCnt == 4'h9) ? 4'h0 : bitCnt + 4'h1;
		end
	end

	// RULE_07 holding word of 30 data and 2 start/end bits
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			linkFull <= 1'b0;
			linkWord <= 32'h0000_0000;
			cursor <= 3'h0;
		end else begin
			linkFull <= next_linkFull;
			if (linkTake) begin
				linkWord <= msgIn;
				cursor <= 3'h0;
			end else if (slotEdge && linkFull) begin
				// RULE_17 next slot continues where this one ended
				cursor <= cursor + ctrl.laneCount;
			end
		end
	end

	for (genvar i = 0; i < LANES; i++) begin : g_lane
		logic [9:0] sh;
		logic rd;
		logic act;
		logic [3:0] idx;
		logic hasData;
		assign act = 3'(i) < ctrl.laneCount;
		assign idx = {1'b0, cursor} + 4'(i);
		assign hasData = linkFull && idx < 4'h4;

		// RULE_01 stripe bytes over active lanes, idle comma otherwise
		always_ff @(posedge clock) begin
			if (sys_rst) begin
				sh <= 10'h000;
				rd <= 1'b0;
			end else if (slotEdge) begin
				// RULE_17 byte i of the slot goes to lane i
				{rd, sh} <= enc8b10b(linkWord[8*(3-idx[1:0]) +: 8], !hasData, rd);
			end else if (linkRise) begin
				sh <= {sh[8:0], 1'b0};
			end
		end

		// RULE_08 serial bit onto the differential pair
		always_ff @(posedge clock) begin
			if (sys_rst) begin
				laneTxP[i] <= 1'b0;
				laneTxN[i] <= 1'b1;
			end else begin
				laneTxP[i] <= act && sh[9];
				laneTxN[i] <= !(act && sh[9]);
			end
		end
	end

	// ----------------------------------------------------------------
	// event pins and debug entry
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		evS1 <= ~eventInN;
		evS2 <= evS1;
		evDly <= evS2;
	end
	assign evRise = evS2 & ~evDly & ~ctrl.evDir;

	// RULE_04 level caught at the first edge after reset release
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			started <= 1'b0;
			debugHalt <= 1'b0;
		end else if (!started) begin
			started <= 1'b1;
			debugHalt <= evS2[0] && !ctrl.evDir[0];
		end else if (doWrite && awAddr == REG_CTRL && wStrb[1] && wData[CTRL_RELEASE_BIT]) begin
			debugHalt <= 1'b0;
		end
	end

	// RULE_03 event input asks for sync or breakpoint
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			syncReq <= 1'b0;
			breakReq <= 1'b0;
		end else begin
			syncReq <= started && |(evRise & ~ctrl.evAction);
			breakReq <= started && |(evRise & ctrl.evAction);
		end
	end

	always_comb begin
		stSet = '0;
		stSet[ST_FULL] = memTake && atEnd && !ctrl.circular;
		stSet[ST_WRAP] = memTake && atEnd && ctrl.circular;
		stSet[ST_EVENT] = started && |evRise;
		stSet[ST_REGION] = take && ctrl.captureEn && ctrl.routeToMem && !regionOk;
		// RULE_11 code ignored once switched
		stSet[ST_SWITCH] = tapIrUpdate && !tapReset && !mainDieScanSel && tapIr == SWITCH_IR;
	end

	// RULE_05 hit stretched over a fixed pulse on output pins
	always_comb begin
		next_evCnt = (evCnt != 3'h0) ? evCnt - 3'h1 : 3'h0;
		if (watchHit || semaphoreHit) begin
			next_evCnt = 3'(EVT_OUT_CYCLES);
		end
	end

	// RULE_06 per-pin direction, pin 0 is the default pin
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			evCnt <= 3'h0;
			eventOutN <= 2'h3;
			eventOeN <= 2'h3;
		end else begin
			evCnt <= next_evCnt;
			eventOutN <= ~(ctrl.evDir & {2{next_evCnt != 3'h0}});
			eventOeN <= ~ctrl.evDir;
		end
	end

	// ----------------------------------------------------------------
	// scan controller switch
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (sys_rst || tapReset) begin
			mainDieScanSel <= 1'b0;
		end else if (stSet[ST_SWITCH]) begin
			// RULE_10 switch code hands over scan control
			mainDieScanSel <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence hitSeen;
		watchHit && ctrl.evDir[0] && $stable(ctrl.evDir);
	endsequence
	sequence pinLow4;
		(!eventOutN[0] && !eventOeN[0]) [*4];
	endsequence
	sequence evInputRise;
		started && evRise[0] && !ctrl.evAction[0];
	endsequence

	chk_lane_quiet_off: assert property (@(posedge clock) disable iff (sys_rst) // RULE_01
		!$past(g_lane[5].act) |-> !laneTxP[5] && laneTxN[5])
		else $error("inactive lane 5 toggles");
	chk_link_word_held: assert property (@(posedge clock) disable iff (sys_rst) // RULE_07
		linkTake |=> linkFull && linkWord == $past(msgIn))
		else $error("link word not captured");
	chk_event_sync_req: assert property (@(posedge clock) disable iff (sys_rst) // RULE_03
		evInputRise |=> syncReq && !breakReq)
		else $error("event input gave no sync request");
	chk_halt_kept: assert property (@(posedge clock) disable iff (sys_rst) // RULE_04
		debugHalt && !(doWrite && awAddr == REG_CTRL) |=> debugHalt)
		else $error("debug halt dropped");
	chk_event_out_pulse: assert property (@(posedge clock) disable iff (sys_rst) // RULE_05
		hitSeen |=> pinLow4)
		else $error("event output pulse too short");
	chk_switch_code: assert property (@(posedge clock) disable iff (sys_rst) // RULE_10
		tapIrUpdate && tapIr == SWITCH_IR && !tapReset |=> mainDieScanSel)
		else $error("switch code not taken");
	chk_switch_ignored: assert property (@(posedge clock) disable iff (sys_rst) // RULE_11
		mainDieScanSel && !tapReset |=> mainDieScanSel && !stSet[ST_SWITCH])
		else $error("scan handover lost");
	chk_oneshot_stop: assert property (@(posedge clock) disable iff (sys_rst) // RULE_14
		memTake && atEnd && !ctrl.circular && !doWrite |=> stopped && status[ST_FULL])
		else $error("one-shot capture did not stop");
	chk_circular_wrap: assert property (@(posedge clock) disable iff (sys_rst) // RULE_14
		memTake && atEnd && ctrl.circular && !doWrite |=> wptr == trBase && !stopped)
		else $error("circular capture did not wrap");
	chk_region_guard: assert property (@(posedge clock) disable iff (sys_rst) // RULE_13
		take && ctrl.captureEn && ctrl.routeToMem && !regionOk |=> status[ST_REGION])
		else $error("bad trace region accepted");
	chk_access_ack: assert property (@(posedge clock) disable iff (sys_rst) // RULE_15
		rwReq && !rwPend |-> ##[1:3] rwAck)
		else $error("access not answered");
endmodule // trace_debug_companion_port

// file: bench/trace_tool_model.sv
// far-side debug tool model: link clock source and lane 0 watcher
`timescale 1ns/10ps
module trace_tool_model (
	input wire logic run, // link clock runs while high
	input wire logic [5:0] laneTxP, // lane positive
	input wire logic [5:0] laneTxN, // lane negative
	output logic linkClkIn, // link clock to the device
	output logic sawComma, // comma symbol seen on lane 0
	output logic diffBad // lane 0 pair not complementary
);
	import trace_port_pkg::*;
	logic [9:0] sym;
	// tool clock at the bit rate, stopped outside traffic
	initial begin
		linkClkIn = 1'b0;
		sym = 10'h000;
		sawComma = 1'b0;
		diffBad = 1'b0;
		#7;
		forever begin
			#80;
			if (run) linkClkIn = ~linkClkIn;
			// lane 0 bit taken on each rise, first bit ends up on top
			if (run && linkClkIn) begin
				if (sym == K285_NEG || sym == K285_POS) sawComma = 1'b1;
				if (laneTxN[0] !== ~laneTxP[0]) diffBad = 1'b1;
				sym = {sym[8:0], laneTxP[0]};
			end
		end
	end
endmodule // trace_tool_model

// file: bench/trace_debug_companion_port_tb.sv
// testbench of the companion debug port
`timescale 1ns/10ps
module trace_debug_companion_port_tb;
	import trace_port_pkg::*;
	logic clock, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic msgValid, msgReady, linkClkIn, watchHit, semaphoreHit, syncReq, breakReq, debugHalt;
	logic tapIrUpdate, tapReset, mainDieScanSel, rwReq, rwWrite, rwAck, irq, run, sawComma, diffBad;
	logic [7:0] s_axi_awaddr, s_axi_araddr, tapIr, rwAddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rwWdata, rwRdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, eventInN, eventOutN, eventOeN, rs;
	logic [5:0] laneTxP, laneTxN;
	logic [2:0] probe;
	msg_type msgIn;
	int failCount, cmpCount;
	assign probe = {rwAck, breakReq, syncReq};
	trace_debug_companion_port i_dut (.*);
	trace_tool_model i_tool (.*);
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmpCount++;
		if (s !== e) begin
			failCount++;
			$display("Error t=%0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic printVerdict();
		$display("compares %0d mismatches %0d", cmpCount, failCount);
		if (failCount == 0 && cmpCount > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic tmo(input int n, input int lim);
		if (n >= lim) begin
			failCount++;
			printVerdict();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
		tmo(n, 50);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		int n;
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
		tmo(n, 50);
		chk(s_axi_rdata, e);
	endtask
	task automatic send(input logic [31:0] m);
		int n;
		@(posedge clock);
		msgIn <= m;
		msgValid <= 1'b1;
		for (n = 0; n < 1000; n++) begin
			@(posedge clock);
			if (msgReady) break;
		end
		msgValid <= 1'b0;
		tmo(n, 1000);
	endtask
	task automatic wt(input int b);
		int n;
		for (n = 0; n < 20; n++) begin
			@(posedge clock);
			if (probe[b]) break;
		end
		tmo(n, 20);
	endtask
	task automatic rwa(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		rwReq <= 1'b1;
		rwWrite <= w;
		rwAddr <= a;
		rwWdata <= d;
		@(posedge clock);
		rwReq <= 1'b0;
		wt(2);
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		int i;
		sys_rst = 1'b1;
		eventInN = 2'b10;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{msgValid, watchHit, semaphoreHit, tapIrUpdate, tapReset, rwReq, rwWrite, run} = '0;
		{s_axi_awaddr, s_axi_araddr, tapIr, rwAddr, s_axi_wdata, rwWdata, msgIn} = '0;
		s_axi_wstrb = 4'hF;
		repeat (3) @(posedge clock);
		sys_rst <= 1'b0;
		repeat (2) @(posedge clock);
		chk(debugHalt, 1'b1);
		eventInN <= 2'b11;
		rdc(REG_CTRL, 32'h8);
		rdc(REG_PART, 32'h1);
		rdc(REG_BASE, 32'h40);
		rdc(REG_SIZE, 32'hC0);
		rdc(8'h24, 32'h0);
		chk(rs, RESP_SLVERR);
		wr(REG_STATE, 32'h1);
		chk(rs, RESP_SLVERR);
		wr(REG_CTRL, 32'h408);
		repeat (2) @(posedge clock);
		chk(debugHalt, 1'b0);
		$display("reset test done");
		// event input: sync request, then breakpoint
		for (i = 0; i < 2; i++) begin
			wr(REG_CTRL, {22'h0, 1'b0, i[0], 8'h08});
			eventInN <= 2'b10;
			wt(i);
			eventInN <= 2'b11;
			repeat (4) @(posedge clock);
		end
		// pin 0 as output, pulsed by each hit source
		wr(REG_CTRL, 32'h48);
		repeat (2) @(posedge clock);
		chk(eventOeN, 2'b10);
		for (i = 0; i < 2; i++) begin
			@(posedge clock);
			{semaphoreHit, watchHit} <= 2'b01 << i;
			@(posedge clock);
			{semaphoreHit, watchHit} <= 2'b00;
			repeat (4) begin
				@(posedge clock);
				chk(eventOutN, 2'b10);
			end
			@(posedge clock);
			chk(eventOutN, 2'b11);
		end
		$display("event test done");
		// scan switch code, its status bit through the interrupt
		tapIr <= SWITCH_IR;
		tapIrUpdate <= 1'b1;
		@(posedge clock);
		tapIrUpdate <= 1'b0;
		repeat (2) @(posedge clock);
		chk(mainDieScanSel, 1'b1);
		chk(irq, 1'b0);
		wr(REG_MASK, 32'h10);
		repeat (2) @(posedge clock);
		chk(irq, 1'b1);
		wr(REG_STATUS, 32'h1F);
		repeat (2) @(posedge clock);
		chk(irq, 1'b0);
		tapReset <= 1'b1;
		repeat (2) @(posedge clock);
		tapReset <= 1'b0;
		chk(mainDieScanSel, 1'b0);
		$display("scan test done");
		// one-shot then circular capture into a two-word buffer
		wr(REG_SIZE, 32'h2);
		wr(REG_CTRL, 32'h0B);
		for (i = 1; i < 4; i++) send(32'hA0000000 | i);
		rdc(REG_STATUS, 32'h1);
		rwa(1'b0, 8'h41, 32'h0);
		chk(rwRdata, 32'hA0000002);
		wr(REG_CTRL, 32'h0F);
		wr(REG_STATUS, 32'h1F);
		wr(REG_BASE, 32'h40);
		for (i = 1; i < 4; i++) send(32'hC0000000 | i);
		rwa(1'b0, 8'h40, 32'h0);
		chk(rwRdata, 32'hC0000003);
		rdc(REG_STATUS, 32'h2);
		rwa(1'b1, 8'h10, 32'h5A5A0F0F);
		rwa(1'b0, 8'h10, 32'h0);
		chk(rwRdata, 32'h5A5A0F0F);
		// all partitions to overlay leaves the buffer outside trace space
		wr(REG_PART, 32'h4);
		wr(REG_PART, 32'h5);
		rdc(REG_PART, 32'h4);
		wr(REG_STATUS, 32'h1F);
		send(32'hA0000009);
		rdc(REG_STATUS, 32'h8);
		wr(REG_PART, 32'h1);
		$display("memory test done");
		// link path with the tool clock running
		wr(REG_CTRL, 32'h09);
		run <= 1'b1;
		send(32'h12345678);
		send(32'h9ABCDEF0);
		repeat (700) @(posedge clock);
		chk(sawComma, 1'b1);
		chk(diffBad, 1'b0);
		chk({laneTxP[5], laneTxN[5]}, 2'b01);
		wr(REG_CTRL, 32'h31);
		repeat (40) @(posedge clock);
		chk(laneTxN[5], {~laneTxP[5]});
		run <= 1'b0;
		$display("link test done");
		printVerdict();
	end
endmodule // trace_debug_companion_port_tb
